/* verilog/cal_ctrl_map.svh */
// Register map, fields, reset values and timing counts of the calibration control bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CAL_CTRL_MAP_SVH
`define CAL_CTRL_MAP_SVH

// Printed offsets are register indices; byte address is four times the index
`define RUN_CTRL_IDX        8'h61
`define MODE_CFG_IDX        8'h62
`define OFFREF_CFG_IDX      8'h65
`define AVERAGING_IDX       8'h68
`define CAL_STATUS_IDX      8'h6A
`define RUN_CTRL_ADDR       12'h184
`define MODE_CFG_ADDR       12'h188
`define OFFREF_CFG_ADDR     12'h194
`define AVERAGING_ADDR      12'h1A0
`define CAL_STATUS_ADDR     12'h1A8

`define RUN_CTRL_RST        8'h01
`define MODE_CFG_RST        8'h01
`define OFFREF_CFG_RST      8'h01
`define AVERAGING_RST       8'h61

`define RUN_BIT             0
`define FG_SEL_BIT          0
`define BG_SEL_BIT          1
`define FG_OS_SEL_BIT       2
`define BG_OS_SEL_BIT       3
`define OFFREF_BIT          2
`define OFFSET_AVERAGE_DEPTH_HI           6
`define OFFSET_AVERAGE_DEPTH_LO           4
`define LIN_AVG_HI          2
`define LIN_AVG_LO          0
`define FOREGROUND_DONE_FLAG_BIT         0
`define STOPPED_BIT         1

`define DIV_RST_HOLD_CYC    4'h4
`define STEP_BASE_CYC       8'h10
`define SHIFT_W             3

`endif

/* verilog/cal_ctrl_pkg.sv */
// Types shared by the calibration control bank.
// Assumes the map header sits on the include path.
`include "cal_ctrl_map.svh"

package cal_ctrl_pkg;

    typedef enum logic [2:0] {
        ST_HOLD    = 3'b000,
        ST_CLEAR   = 3'b001,
        ST_FG_LIN  = 3'b010,
        ST_FG_OFFS = 3'b011,
        ST_BG_RUN  = 3'b100,
        ST_IDLE    = 3'b101
    } cal_state_e;

    typedef logic [7:0] reg8_t;

endpackage

/* verilog/cal_step_timer.sv */
// Step timer: counts the length of one calibration step scaled by an averaging depth.
// Assumes a start pulse from the sequencer; clock enable freezes it.
`timescale 1ns/1ps
`include "cal_ctrl_map.svh"

module cal_step_timer #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_ce,
    // Control
    input  wire logic             i_start,
    input  wire logic             i_abort,
    input  wire logic [2:0]       i_depth,
    output logic                  o_done
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             busy;
        logic             done;
    } tmr_s;

    tmr_s tmr_q;
    tmr_s tmr_d;

    always_comb begin
        tmr_d      = tmr_q;
        tmr_d.done = 1'b0;
        if (i_abort) begin
            tmr_d.busy = 1'b0;
            tmr_d.cnt  = '0;
        end else if (i_start) begin
            // More averaging gives a longer step
            tmr_d.busy = 1'b1;
            tmr_d.cnt  = CNT_W'({`STEP_BASE_CYC, 8'h00} >> (`SHIFT_W'(7) - i_depth));
        end else if (tmr_q.busy) begin
            if (tmr_q.cnt == '0) begin
                tmr_d.busy = 1'b0;
                tmr_d.done = 1'b1;
            end else begin
                tmr_d.cnt = tmr_q.cnt - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tmr_q <= '0;
        end else if (i_ce) begin
            tmr_q <= tmr_d;
        end
    end

    assign o_done = tmr_q.done;

endmodule

/* verilog/cal_ctrl_regs.sv */
// Calibration control registers with an APB slave and a small calibration sequencer.
// Assumes one clock, APB master in the same domain, link enable supplied by the system.
//
// Overview of operation
// RL1 - Run bit high lets calibration run, low holds the engine in reset, and it resets to one.
// RL2 - Clearing the run bit also resets the digital-block and serial-link clock dividers.
// RL3 - Software clears the run bit before rewriting protected calibration registers.
// RL4 - Software sets the run bit before enabling the serial link and disables the link before clearing it.
// RL5 - Software writes reserved fields with their reset values, the offset reference low bits as one.
// RL6 - Foreground select high resets values then runs foreground calibration, low resets and skips it.
// RL7 - Bit 1 of the mode register enables background calibration and resets to zero.
// RL8 - Background offset calibration runs only when background calibration is enabled too.
// RL9 - Foreground offset calibration runs only when foreground select is set, default off.
// RL10 - Offset reference zero calibrates toward mid-code.
// RL11 - Offset reference one aligns each primary converter to its spare converter.
// RL12 - Software selects the spare reference only while background calibration is enabled.
// RL13 - Bits 6 to 4 of the averaging register set offset averaging depth, reset six.
// RL14 - Bits 2 to 0 of the averaging register set linearity averaging depth, reset one.
// RL15 - Foreground-done status rises when foreground calibration completes or is skipped.
// RL16 - Each zero-to-one change of the run bit starts a new calibration sequence.
`timescale 1ns/1ps
`include "cal_ctrl_map.svh"

module cal_ctrl_regs #(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 16
) (
    // Clock, reset, enable
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_ARST_N,
    input  wire logic              I_CE,
    // APB slave
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    // System status
    input  wire logic              I_SERIAL_LINK_ENABLE,
    // Calibration engine controls
    output logic                   O_CAL_ENGINE_RST,
    output logic                   O_DIV_RST,
    output logic                   O_CAL_VALUES_CLR,
    output logic                   O_FG_LIN_ACTIVE,
    output logic                   O_FG_OFFS_ACTIVE,
    output logic                   O_BG_ACTIVE,
    output logic                   O_BG_OFFS_ACTIVE,
    output logic                   O_OFFS_REF_SPARE,
    output logic      [2:0]        O_OFFSET_AVERAGE_DEPTH,
    output logic      [2:0]        O_LINEARITY_AVERAGE_DEPTH,
    output logic                   O_FOREGROUND_DONE_FLAG,
    output logic                   O_ORDER_VIOLATION
);

    typedef struct packed {
        cal_ctrl_pkg::reg8_t      run_ctrl;
        cal_ctrl_pkg::reg8_t      mode_cfg;
        cal_ctrl_pkg::reg8_t      offref_cfg;
        cal_ctrl_pkg::reg8_t      averaging;
        cal_ctrl_pkg::cal_state_e state;
        logic                     run_prev;
        logic [3:0]               div_cnt;
        logic                     foreground_done_flag;
        logic                     stopped;
        logic                     order_err;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
        logic                     start;
        logic                     eng_rst;
        logic                     div_rst;
        logic                     clr;
        logic                     fg_lin;
        logic                     fg_offs;
        logic                     bg;
        logic                     bg_offs;
    } regs_s;

    regs_s q;
    regs_s d;
    logic  step_done;

    // Address decode, used for both read and write paths
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_W'(`RUN_CTRL_ADDR):   reg_sel = 3'h1;
            ADDR_W'(`MODE_CFG_ADDR):   reg_sel = 3'h2;
            ADDR_W'(`OFFREF_CFG_ADDR): reg_sel = 3'h3;
            ADDR_W'(`AVERAGING_ADDR):  reg_sel = 3'h4;
            ADDR_W'(`CAL_STATUS_ADDR): reg_sel = 3'h5;
            default:                   reg_sel = 3'h0;
        endcase
    endfunction

    wire logic       access = I_PSEL && I_PENABLE && !q.pready;
    wire logic [2:0] sel    = reg_sel(I_PADDR);
    wire logic       run    = q.run_ctrl[`RUN_BIT];
    wire logic       fg_sel = q.mode_cfg[`FG_SEL_BIT];
    wire logic       bg_sel = q.mode_cfg[`BG_SEL_BIT];
    wire logic [2:0] offset_average_depth = q.averaging[`OFFSET_AVERAGE_DEPTH_HI:`OFFSET_AVERAGE_DEPTH_LO];
    wire logic [2:0] ln_avg = q.averaging[`LIN_AVG_HI:`LIN_AVG_LO];
    wire logic [2:0] cur_depth = (q.state == cal_ctrl_pkg::ST_FG_OFFS) ? offset_average_depth : ln_avg;

    always_comb begin
        d         = q;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.start   = 1'b0;
        d.run_prev = run;
        // APB access answers one cycle after the access phase begins
        if (access) begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            if (sel == 3'h0) begin
                d.pslverr = 1'b1;
            end else if (I_PWRITE) begin
                case (sel)
                    3'h1: d.run_ctrl   = I_PWDATA[7:0];
                    3'h2: d.mode_cfg   = I_PWDATA[7:0];
                    3'h3: d.offref_cfg = I_PWDATA[7:0];
                    3'h4: d.averaging  = I_PWDATA[7:0];
                    3'h5: d.pslverr    = 1'b1;
                    default: d.pslverr = 1'b1;
                endcase
                // Link must be off before the run bit clears
                if (sel == 3'h1 && !I_PWDATA[`RUN_BIT] && I_SERIAL_LINK_ENABLE) begin
                    d.order_err = 1'b1; // [RL4]
                end
            end else begin
                case (sel)
                    3'h1: d.prdata = {24'h000000, q.run_ctrl};
                    3'h2: d.prdata = {24'h000000, q.mode_cfg};
                    3'h3: d.prdata = {24'h000000, q.offref_cfg};
                    3'h4: d.prdata = {24'h000000, q.averaging};
                    3'h5: d.prdata = {30'h0000_0000, q.stopped, q.foreground_done_flag};
                    default: d.prdata = 32'h0000_0000;
                endcase
            end
        end
        // Run bit low freezes the engine and its dividers
        if (!run) begin
            d.state   = cal_ctrl_pkg::ST_HOLD; // [RL1]
            d.div_cnt = `DIV_RST_HOLD_CYC; // [RL2]
            d.foreground_done_flag = 1'b0;
            d.stopped = 1'b0;
        end else begin
            if (q.div_cnt != 4'h0) begin
                d.div_cnt = q.div_cnt - 4'h1;
            end
            case (q.state)
                cal_ctrl_pkg::ST_HOLD: begin
                    if (!q.run_prev) begin
                        d.state = cal_ctrl_pkg::ST_CLEAR; // [RL16]
                    end
                end
                cal_ctrl_pkg::ST_CLEAR: begin
                    // Values always cleared first, foreground optional
                    if (fg_sel) begin
                        d.state = cal_ctrl_pkg::ST_FG_LIN; // [RL6]
                        d.start = 1'b1;
                    end else begin
                        d.foreground_done_flag = 1'b1; // [RL15]
                        d.stopped = !bg_sel;
                        d.state   = bg_sel ? cal_ctrl_pkg::ST_BG_RUN : cal_ctrl_pkg::ST_IDLE;
                    end
                end
                cal_ctrl_pkg::ST_FG_LIN: begin
                    if (step_done) begin
                        if (q.mode_cfg[`FG_OS_SEL_BIT]) begin
                            d.state = cal_ctrl_pkg::ST_FG_OFFS; // [RL9]
                            d.start = 1'b1;
                        end else begin
                            d.foreground_done_flag = 1'b1; // [RL15]
                            d.stopped = !bg_sel;
                            d.state   = bg_sel ? cal_ctrl_pkg::ST_BG_RUN : cal_ctrl_pkg::ST_IDLE;
                        end
                    end
                end
                cal_ctrl_pkg::ST_FG_OFFS: begin
                    if (step_done) begin
                        d.foreground_done_flag = 1'b1; // [RL15]
                        d.stopped = !bg_sel;
                        d.state   = bg_sel ? cal_ctrl_pkg::ST_BG_RUN : cal_ctrl_pkg::ST_IDLE; // [RL7]
                    end
                end
                cal_ctrl_pkg::ST_BG_RUN: begin
                    if (!bg_sel) begin
                        d.state   = cal_ctrl_pkg::ST_IDLE;
                        d.stopped = 1'b1;
                    end
                end
                cal_ctrl_pkg::ST_IDLE: begin
                    d.state = cal_ctrl_pkg::ST_IDLE;
                end
                default: d.state = cal_ctrl_pkg::ST_HOLD;
            endcase
        end
        // Phase outputs registered from the next state, so no decode glitch reaches the engine
        d.eng_rst = (d.state == cal_ctrl_pkg::ST_HOLD);
        d.div_rst = (d.div_cnt != 4'h0);
        d.clr     = (d.state == cal_ctrl_pkg::ST_CLEAR);
        d.fg_lin  = (d.state == cal_ctrl_pkg::ST_FG_LIN);
        d.fg_offs = (d.state == cal_ctrl_pkg::ST_FG_OFFS);
        d.bg      = (d.state == cal_ctrl_pkg::ST_BG_RUN);
        // Background offset needs background enabled as well
        d.bg_offs = (d.state == cal_ctrl_pkg::ST_BG_RUN) && d.mode_cfg[`BG_OS_SEL_BIT]; // [RL8]
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            q            <= '0;
            q.run_ctrl   <= `RUN_CTRL_RST; // [RL1]
            q.mode_cfg   <= `MODE_CFG_RST; // [RL6]
            q.offref_cfg <= `OFFREF_CFG_RST;
            q.averaging  <= `AVERAGING_RST; // [RL13] [RL14]
            q.run_prev   <= 1'b0;
            q.state      <= cal_ctrl_pkg::ST_HOLD;
            q.eng_rst    <= 1'b1;
        end else if (I_CE) begin
            q <= d;
        end
    end

    cal_step_timer #(
        .CNT_W    (CNT_W)
    ) u_timer (
        .i_clk    (I_SYS_CLK),
        .i_arst_n (I_ARST_N),
        .i_ce     (I_CE),
        .i_start  (q.start),
        .i_abort  (!run),
        .i_depth  (cur_depth),
        .o_done   (step_done)
    );

    // Outputs come straight from state flip-flops
    assign O_PRDATA                  = q.prdata;
    assign O_PREADY                  = q.pready;
    assign O_PSLVERR                 = q.pslverr;
    assign O_CAL_ENGINE_RST          = q.eng_rst; // [RL1]
    assign O_DIV_RST                 = q.div_rst; // [RL2]
    assign O_CAL_VALUES_CLR          = q.clr;
    assign O_FG_LIN_ACTIVE           = q.fg_lin;
    assign O_FG_OFFS_ACTIVE          = q.fg_offs;
    assign O_BG_ACTIVE               = q.bg;
    assign O_BG_OFFS_ACTIVE          = q.bg_offs;
    // Zero selects mid-code target, one the spare converter
    assign O_OFFS_REF_SPARE          = q.offref_cfg[`OFFREF_BIT]; // [RL10] [RL11]
    assign O_OFFSET_AVERAGE_DEPTH    = offset_average_depth; // [RL13]
    assign O_LINEARITY_AVERAGE_DEPTH = ln_avg; // [RL14]
    assign O_FOREGROUND_DONE_FLAG    = q.foreground_done_flag;
    assign O_ORDER_VIOLATION         = q.order_err;

    // Assertions
    sequence run_fall_s;
        I_CE && $fell(run);
    endsequence

    run_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL1]
        run_fall_s |=> O_CAL_ENGINE_RST && O_DIV_RST)
        else $error("engine not held after run cleared");

    div_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL2]
        (I_CE && !run) |=> O_DIV_RST)
        else $error("dividers not in reset while run low");

    restart_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL16]
        (I_CE && q.state == cal_ctrl_pkg::ST_HOLD && run && !q.run_prev) |=> O_CAL_VALUES_CLR)
        else $error("no restart on run rise");

    fg_skip_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL6]
        (I_CE && run && O_CAL_VALUES_CLR && !fg_sel) |=> !O_FG_LIN_ACTIVE && O_FOREGROUND_DONE_FLAG)
        else $error("foreground not skipped");

    foreground_done_flag_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL15]
        (I_CE && run && O_FG_OFFS_ACTIVE && step_done) |=> O_FOREGROUND_DONE_FLAG)
        else $error("done flag missing");

    // Linearity step ending with foreground offset deselected
    sequence lin_end_s;
        I_CE && run && O_FG_LIN_ACTIVE && step_done && !q.mode_cfg[`FG_OS_SEL_BIT];
    endsequence

    lin_done_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL15]
        lin_end_s |=> O_FOREGROUND_DONE_FLAG && !O_FG_OFFS_ACTIVE)
        else $error("done flag missing after linearity");

    bg_offs_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL8]
        O_BG_OFFS_ACTIVE |-> q.mode_cfg[`BG_SEL_BIT] || $past(q.mode_cfg[`BG_SEL_BIT]))
        else $error("bg offset without bg");

    fg_offs_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL9]
        $rose(O_FG_OFFS_ACTIVE) |-> $past(q.mode_cfg[`FG_OS_SEL_BIT]) && $past(O_FG_LIN_ACTIVE))
        else $error("fg offset without fg linearity");

    bg_enter_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL7]
        $rose(O_BG_ACTIVE) |-> $past(bg_sel))
        else $error("background entered while disabled");

    avg_out_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL13] [RL14]
        (I_CE && access && I_PWRITE && sel == 3'h4) |=>
            O_OFFSET_AVERAGE_DEPTH == $past(I_PWDATA[`OFFSET_AVERAGE_DEPTH_HI:`OFFSET_AVERAGE_DEPTH_LO]) &&
            O_LINEARITY_AVERAGE_DEPTH == $past(I_PWDATA[`LIN_AVG_HI:`LIN_AVG_LO]))
        else $error("averaging depth not applied");

    ref_out_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // [RL10]
        (I_CE && access && I_PWRITE && sel == 3'h3) |=> O_OFFS_REF_SPARE == $past(I_PWDATA[`OFFREF_BIT]))
        else $error("offset reference not applied");

endmodule

/* bench/test_cal_ctrl_regs.sv */
// Self-checking bench for the calibration control bank: APB register access and sequencer phases.
// Assumes the map header on the include path and the design's embedded assertions.
`timescale 1ns/1ps
`include "cal_ctrl_map.svh"

module test_cal_ctrl_regs;

    logic        clk;
    logic        arst_n;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        link;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        eng_rst;
    logic        div_rst;
    logic        clr;
    logic        fg_lin;
    logic        fg_offs;
    logic        bg;
    logic        bg_offs;
    logic        spare;
    logic        done;
    logic        viol;
    logic [2:0]  os_depth;
    logic [2:0]  lin_depth;
    logic [31:0] rd;
    logic        err;
    int          failures;
    int          total_checks;
    int          cycles;
    int          clr_n;
    int          lin_n;
    int          offs_n;
    int          bgos_n;

    cal_ctrl_regs dut (
        .I_SYS_CLK                 (clk),
        .I_ARST_N                  (arst_n),
        .I_CE                      (ce),
        .I_PSEL                    (psel),
        .I_PENABLE                 (penable),
        .I_PWRITE                  (pwrite),
        .I_PADDR                   (paddr),
        .I_PWDATA                  (pwdata),
        .O_PRDATA                  (prdata),
        .O_PREADY                  (pready),
        .O_PSLVERR                 (pslverr),
        .I_SERIAL_LINK_ENABLE      (link),
        .O_CAL_ENGINE_RST          (eng_rst),
        .O_DIV_RST                 (div_rst),
        .O_CAL_VALUES_CLR          (clr),
        .O_FG_LIN_ACTIVE           (fg_lin),
        .O_FG_OFFS_ACTIVE          (fg_offs),
        .O_BG_ACTIVE               (bg),
        .O_BG_OFFS_ACTIVE          (bg_offs),
        .O_OFFS_REF_SPARE          (spare),
        .O_OFFSET_AVERAGE_DEPTH    (os_depth),
        .O_LINEARITY_AVERAGE_DEPTH (lin_depth),
        .O_FOREGROUND_DONE_FLAG    (done),
        .O_ORDER_VIOLATION         (viol)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim;
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Phase cycle counters; scenarios compare differences, so no reset is needed
    always @(posedge clk) begin
        cycles++;
        if (clr === 1'b1) clr_n++;
        if (fg_lin === 1'b1) lin_n++;
        if (fg_offs === 1'b1) offs_n++;
        if (bg_offs === 1'b1) bgos_n++;
        if (cycles == 20000) begin
            failures++;
            $display("wrong value at %0t: run did not finish in time", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Request held until pready is sampled high; released at that same edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(n < 50, 1, "apb answer");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk(err, 0, "write error");
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, msg);
        chk(err, 0, "read error");
    endtask

    task automatic wait_done(output int n);
        n = 0;
        while (done !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk(done, 1, "foreground done");
    endtask

    task automatic t_reset;
        int n;
        chk(os_depth, 6, "offset depth reset");
        chk(lin_depth, 1, "linearity depth reset");
        rdc(`RUN_CTRL_ADDR, 32'h01, "run reset");
        rdc(`MODE_CFG_ADDR, 32'h01, "mode reset");
        rdc(`OFFREF_CFG_ADDR, 32'h01, "offref reset");
        rdc(`AVERAGING_ADDR, 32'h61, "averaging reset");
        wait_done(n);
        chk(eng_rst, 0, "engine running");
    endtask

    task automatic t_refuse;
        apb(1'b0, 12'h1FC, 32'h0);
        chk(err, 1, "unmapped read");
        apb(1'b1, `CAL_STATUS_ADDR, 32'h000000FF);
        chk(err, 1, "status write");
        rdc(`RUN_CTRL_ADDR, 32'h01, "run untouched");
    endtask

    // Full foreground with both offset routines, then background with offset
    task automatic t_fg_full;
        int c0;
        int l0;
        int o0;
        int n;
        link <= 1'b0;
        wr(`RUN_CTRL_ADDR, 32'h00);
        tick(2);
        chk(eng_rst, 1, "engine held");
        chk(div_rst, 1, "dividers held");
        chk(done, 0, "done cleared");
        chk(viol, 0, "no violation");
        wr(`MODE_CFG_ADDR, 32'h0F);
        wr(`AVERAGING_ADDR, 32'h10);
        wr(`OFFREF_CFG_ADDR, 32'h05);
        rdc(`MODE_CFG_ADDR, 32'h0F, "mode readback");
        rdc(`AVERAGING_ADDR, 32'h10, "averaging readback");
        chk(spare, 1, "spare reference");
        chk(os_depth, 1, "offset depth");
        chk(lin_depth, 0, "linearity depth");
        chk(fg_lin, 0, "held, no phase");
        c0 = clr_n;
        l0 = lin_n;
        o0 = offs_n;
        wr(`RUN_CTRL_ADDR, 32'h01);
        tick(8);
        chk(div_rst, 0, "dividers released");
        wait_done(n);
        tick(4);
        chk(clr_n - c0, 1, "values cleared once");
        chk(lin_n - l0, 35, "linearity length");
        chk(offs_n - o0, 67, "offset length");
        chk(bg, 1, "background active");
        chk(bg_offs, 1, "background offset");
        link <= 1'b1;
        tick(1);
        chk(viol, 0, "link after run set");
    endtask

    // Offset selects without their parents must do nothing; foreground skipped
    task automatic t_skip;
        int c0;
        int l0;
        int o0;
        int b0;
        int n;
        link <= 1'b0;
        wr(`RUN_CTRL_ADDR, 32'h00);
        wr(`MODE_CFG_ADDR, 32'h0C);
        wr(`OFFREF_CFG_ADDR, 32'h01);
        chk(spare, 0, "mid-code reference");
        c0 = clr_n;
        l0 = lin_n;
        o0 = offs_n;
        b0 = bgos_n;
        wr(`RUN_CTRL_ADDR, 32'h01);
        wait_done(n);
        chk(n < 8, 1, "skip done soon");
        tick(4);
        chk(clr_n - c0, 1, "values cleared on skip");
        chk(lin_n - l0, 0, "no linearity");
        chk(offs_n - o0, 0, "no fg offset");
        chk(bgos_n - b0, 0, "no bg offset");
        chk(bg, 0, "no background");
        rdc(`CAL_STATUS_ADDR, 32'h03, "status done");
    endtask

    // Sticky flag, so this runs last
    task automatic t_order;
        link <= 1'b1;
        wr(`RUN_CTRL_ADDR, 32'h00);
        tick(2);
        chk(viol, 1, "order violation");
        chk(div_rst, 1, "dividers held");
    endtask

    initial begin
        failures     = 0;
        total_checks = 0;
        cycles       = 0;
        clr_n        = 0;
        lin_n        = 0;
        offs_n       = 0;
        bgos_n       = 0;
        arst_n       = 1'b0;
        ce           = 1'b1;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 12'h000;
        pwdata       = 32'h0;
        link         = 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_refuse();
        t_fg_full();
        t_skip();
        t_order();
        end_sim();
    end

endmodule
